// ### eep_defines.vh
`ifndef EEP_DEFINES_VH
`define EEP_DEFINES_VH

`define EEP_ADDR_W         15
`define EEP_PAGE_W         6
`define EEP_PAGE_BYTES     64
`define EEP_PAGES          512
`define EEP_DEV_CODE       4'ha
`define EEP_CLK_MHZ        50
`define EEP_PROG_TIME_US   5000
`define EEP_PROG_CYCLES    (`EEP_PROG_TIME_US * `EEP_CLK_MHZ)
`define EEP_TMR_W          18

`endif

// ### eep_sync.v
`timescale 1ns/1ps
`default_nettype none
module eep_sync #(
  parameter W    = 1,
  parameter INIT = 1'b0
) (
  input  wire         clk_i,
  input  wire         reset_n_i,
  input  wire [W-1:0] async_i,
  output reg  [W-1:0] sync_o
);
  reg [W-1:0] meta_q;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= {W{INIT}};
      sync_o <= {W{INIT}};
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // eep_sync
`default_nettype wire

// ### eep_serial_eeprom.v
`timescale 1ns/1ps
`default_nettype none
`include "eep_defines.vh"
module eep_serial_eeprom #(
  parameter PROG_CYCLES = `EEP_PROG_CYCLES
) (
  input  wire       clk_i,
  input  wire       reset_n_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_n_o,
  input  wire [2:0] chip_select_inputs_i,
  input  wire       write_inhibit_i,
  output reg        busy_o
);
  localparam AW = `EEP_ADDR_W;
  localparam PW = `EEP_PAGE_W;

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_DEV  = 3'h1;
  localparam [2:0] ST_AHI  = 3'h2;
  localparam [2:0] ST_ALO  = 3'h3;
  localparam [2:0] ST_WR   = 3'h4;
  localparam [2:0] ST_RD   = 3'h5;

  wire       scl_s;
  wire       sda_s;
  wire [2:0] cs_s;
  wire       wi_s;

  // clock and data idle high on the bus
  eep_sync #(.W(2), .INIT(1'b1)) u_sync_bus (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({scl_i, sda_i}),
    .sync_o    ({scl_s, sda_s})
  );

  // a floating strap is expected to be pulled low on the pin
  eep_sync #(.W(4), .INIT(1'b0)) u_sync_strap (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({chip_select_inputs_i, write_inhibit_i}),
    .sync_o    ({cs_s, wi_s})
  );

  reg [7:0] mem [0:(`EEP_PAGES*`EEP_PAGE_BYTES)-1];
  reg [7:0] page_buf [0:`EEP_PAGE_BYTES-1];

  reg                     scl_q;
  reg                     sda_q;
  reg [2:0]               state_q;
  reg [3:0]               bit_q;
  reg [7:0]               shreg_q;
  reg                     ack_q;
  reg                     rack_q;
  reg                     mack_q;
  reg                     rw_q;
  reg [AW-1:0]            addr_q;
  reg [`EEP_PAGE_BYTES-1:0] valid_q;
  reg [`EEP_TMR_W-1:0]    tmr_q;

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_ev = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_ev  = scl_s & scl_q & ~sda_q & sda_s;
  wire [7:0] rd_byte = mem[addr_q];

  function [PW-1:0] page_inc;
    input [PW-1:0] a;
    begin
      page_inc = a + {{(PW-1){1'b0}}, 1'b1};
    end
  endfunction

  function [AW-1:0] addr_inc;
    input [AW-1:0] a;
    begin
      addr_inc = a + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  // internal program cycle: copy buffered bytes, then wait out the program time
  always @(posedge clk_i) begin
    if (busy_o && tmr_q < `EEP_PAGE_BYTES && valid_q[tmr_q[PW-1:0]]) begin
      mem[{addr_q[AW-1:PW], tmr_q[PW-1:0]}] <= page_buf[tmr_q[PW-1:0]];
    end
  end

  always @(posedge clk_i) begin
    if (state_q == ST_WR && scl_fall && !ack_q && bit_q == 4'h8) begin
      page_buf[addr_q[PW-1:0]] <= shreg_q;
    end
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      state_q    <= ST_IDLE;
      bit_q      <= 4'h0;
      shreg_q    <= 8'h00;
      ack_q      <= 1'b0;
      rack_q     <= 1'b0;
      mack_q     <= 1'b0;
      rw_q       <= 1'b0;
      addr_q     <= {AW{1'b0}};
      valid_q    <= {`EEP_PAGE_BYTES{1'b0}};
      tmr_q      <= {`EEP_TMR_W{1'b0}};
      busy_o     <= 1'b0;
      sda_o      <= 1'b0;
      sda_oe_n_o <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      sda_o <= 1'b0;
      if (busy_o) begin
        // inputs are ignored until the program cycle ends
        sda_oe_n_o <= 1'b1;
        state_q    <= ST_IDLE;
        if (tmr_q == PROG_CYCLES - 1) begin
          busy_o  <= 1'b0;
          tmr_q   <= {`EEP_TMR_W{1'b0}};
          valid_q <= {`EEP_PAGE_BYTES{1'b0}};
        end else begin
          tmr_q <= tmr_q + {{(`EEP_TMR_W-1){1'b0}}, 1'b1};
        end
      end else if (start_ev) begin
        state_q    <= ST_DEV;
        bit_q      <= 4'h0;
        ack_q      <= 1'b0;
        rack_q     <= 1'b0;
        sda_oe_n_o <= 1'b1;
        valid_q    <= {`EEP_PAGE_BYTES{1'b0}};
      end else if (stop_ev) begin
        state_q    <= ST_IDLE;
        ack_q      <= 1'b0;
        rack_q     <= 1'b0;
        sda_oe_n_o <= 1'b1;
        if (state_q == ST_WR && |valid_q) begin
          if (!wi_s) begin
            busy_o <= 1'b1;
            tmr_q  <= {`EEP_TMR_W{1'b0}};
          end else begin
            valid_q <= {`EEP_PAGE_BYTES{1'b0}};
          end
        end
      end else if (state_q == ST_RD) begin
        if (scl_rise && rack_q) begin
          mack_q <= ~sda_s;
        end else if (scl_fall) begin
          if (rack_q) begin
            rack_q <= 1'b0;
            if (mack_q) begin
              shreg_q    <= rd_byte;
              sda_oe_n_o <= rd_byte[7];
              addr_q     <= addr_inc(addr_q);
              bit_q      <= 4'h1;
            end else begin
              state_q    <= ST_IDLE;
              sda_oe_n_o <= 1'b1;
            end
          end else if (bit_q == 4'h8) begin
            sda_oe_n_o <= 1'b1;
            rack_q     <= 1'b1;
          end else begin
            sda_oe_n_o <= shreg_q[6];
            shreg_q    <= {shreg_q[6:0], 1'b0};
            bit_q      <= bit_q + 4'h1;
          end
        end
      end else if (state_q != ST_IDLE) begin
        if (scl_rise && !ack_q) begin
          shreg_q <= {shreg_q[6:0], sda_s};
          bit_q   <= bit_q + 4'h1;
        end else if (scl_fall && ack_q) begin
          ack_q <= 1'b0;
          bit_q <= 4'h0;
          case (state_q)
            ST_DEV: begin
              if (rw_q) begin
                state_q    <= ST_RD;
                shreg_q    <= rd_byte;
                sda_oe_n_o <= rd_byte[7];
                addr_q     <= addr_inc(addr_q);
                bit_q      <= 4'h1;
              end else begin
                state_q    <= ST_AHI;
                sda_oe_n_o <= 1'b1;
              end
            end
            ST_AHI: begin
              state_q    <= ST_ALO;
              sda_oe_n_o <= 1'b1;
            end
            default: begin
              state_q    <= ST_WR;
              sda_oe_n_o <= 1'b1;
            end
          endcase
        end else if (scl_fall && bit_q == 4'h8) begin
          case (state_q)
            ST_DEV: begin
              if (shreg_q[7:4] == `EEP_DEV_CODE && shreg_q[3:1] == cs_s) begin
                rw_q       <= shreg_q[0];
                ack_q      <= 1'b1;
                sda_oe_n_o <= 1'b0;
              end else begin
                state_q <= ST_IDLE;
              end
            end
            ST_AHI: begin
              addr_q[AW-1:8] <= shreg_q[6:0];
              ack_q          <= 1'b1;
              sda_oe_n_o     <= 1'b0;
            end
            ST_ALO: begin
              addr_q[7:0] <= shreg_q;
              ack_q       <= 1'b1;
              sda_oe_n_o  <= 1'b0;
            end
            ST_WR: begin
              valid_q[addr_q[PW-1:0]] <= 1'b1;
              addr_q[PW-1:0]          <= page_inc(addr_q[PW-1:0]);
              ack_q                   <= 1'b1;
              sda_oe_n_o              <= 1'b0;
            end
            default: begin
              state_q <= ST_IDLE;
            end
          endcase
        end
      end
    end
  end
endmodule // eep_serial_eeprom
`default_nettype wire

// ### eep_serial_eeprom_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module eep_chk #(
  parameter PROG_CYCLES = 100
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic write_inhibit_i,
  input wire logic busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [17:0] n_q;
  // length of the current program cycle
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) n_q <= '0;
    else n_q <= busy_o ? n_q + 18'h1 : '0;
  sequence s_held;
    $stable(sda_oe_n_o) [*6];
  endsequence
  sequence s_stop_seen;
    $past(scl_i) && $past(sda_i);
  endsequence
  chk_sda_low_only: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  chk_reset_idle: assert property ($rose(reset_n_i) |-> sda_oe_n_o && !busy_o)
    else $error("pin or busy active after reset");
  chk_drive_clk_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("data drive moved with clock high");
  chk_drive_after_fall: assert property ($changed(sda_oe_n_o) |-> !$past(scl_i, 2))
    else $error("data drive moved before clock fall");
  chk_bit_hold: assert property ($changed(sda_oe_n_o) |=> s_held)
    else $error("driven bit not held for the clock");
  chk_busy_len: assert property ($fell(busy_o) |-> n_q >= 64 && n_q <= PROG_CYCLES)
    else $error("program cycle length wrong");
  chk_busy_deaf: assert property (busy_o |-> sda_oe_n_o)
    else $error("answer given while busy");
  chk_busy_on_stop: assert property ($rose(busy_o) |-> s_stop_seen)
    else $error("program cycle began without stop");
  chk_inhibit_block: assert property ($rose(busy_o) |-> !write_inhibit_i)
    else $error("program cycle while inhibited");
endmodule // eep_chk
bind eep_serial_eeprom eep_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .write_inhibit_i(write_inhibit_i), .busy_o(busy_o));
`default_nettype wire

// ### eep_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module eep_ctrl (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic t(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // data moves with the clock high only in start and stop
  task automatic start;
    t(2); sda_low_o = 1'b0; t(2); scl_o = 1'b1;
    t(4); sda_low_o = 1'b1; t(4); scl_o = 1'b0;
  endtask
  task automatic stop;
    t(2); sda_low_o = 1'b1; t(2); scl_o = 1'b1;
    t(4); sda_low_o = 1'b0; t(4);
  endtask
  // nine clocks msb first, data changed while clock low
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      t(2); sda_low_o = !tx[i]; t(2); scl_o = 1'b1;
      t(2); rx[i] = sda_i; t(2); scl_o = 1'b0;
    end
  endtask
endmodule // eep_ctrl
`default_nettype wire

// ### tb_serial_eeprom_select_and_protect.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_select_and_protect;
  logic       clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       wi = 1'b0;
  logic [2:0] cs = 3'h0;
  logic [8:0] r;
  wire        scl, ctl_low, sda_o, oe_n, busy;
  wire        sda = (ctl_low || (!oe_n && !sda_o)) ? 1'b0 : 1'b1;
  int         n_mismatch = 0;
  int         checks_done = 0;
  always #10 clk_i = ~clk_i;
  eep_serial_eeprom #(.PROG_CYCLES(200)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(oe_n),
    .chip_select_inputs_i(cs), .write_inhibit_i(wi), .busy_o(busy));
  eep_ctrl i_ctrl (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(ctl_low));
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task dev(input logic [3:0] code, input logic [2:0] a, input logic rd);
    i_ctrl.start();
    i_ctrl.xfer({code, a, rd, 1'b1}, r);
  endtask
  task wb(input logic [7:0] d);
    i_ctrl.xfer({d, 1'b1}, r);
    chk("ack", 8'h00, {7'h0, r[0]});
  endtask
  task setaddr(input logic [7:0] hi, input logic [7:0] lo);
    dev(4'ha, cs, 1'b0);
    chk("dev ack", 8'h00, {7'h0, r[0]});
    wb(hi);
    wb(lo);
  endtask
  task wait_idle;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk_i);
    chk("busy end", 8'h00, {7'h0, busy});
    if (busy !== 1'b0) conclude();
  endtask
  task rd2(input logic [7:0] hi, lo, e0, e1);
    setaddr(hi, lo);
    dev(4'ha, cs, 1'b1);
    chk("rd ack", 8'h00, {7'h0, r[0]});
    i_ctrl.xfer(9'h1fe, r);
    chk("rd", e0, r[8:1]);
    i_ctrl.xfer(9'h1ff, r);
    chk("rd", e1, r[8:1]);
    i_ctrl.stop();
  endtask
  task s_page;
    setaddr(8'hff, 8'hfe);
    wb(8'ha1);
    wb(8'hb2);
    wb(8'hc3);
    wb(8'hd4);
    i_ctrl.stop();
    dev(4'ha, cs, 1'b0);
    chk("poll", 8'h01, {7'h0, r[0]});
    i_ctrl.stop();
    wait_idle();
  endtask
  task s_protect;
    wi = 1'b1;
    setaddr(8'h7f, 8'hc0);
    wb(8'h55);
    i_ctrl.stop();
    repeat (20) @(negedge clk_i);
    chk("busy", 8'h00, {7'h0, busy});
    wi = 1'b0;
    rd2(8'h7f, 8'hc0, 8'hc3, 8'hd4);
  endtask
  task s_select;
    cs = 3'h5;
    for (int k = 0; k < 8; k++) begin
      dev(4'ha, k[2:0], 1'b0);
      chk("sel", (k == 5) ? 8'h00 : 8'h01, {7'h0, r[0]});
      i_ctrl.stop();
    end
    dev(4'hb, 3'h5, 1'b0);
    chk("code", 8'h01, {7'h0, r[0]});
    i_ctrl.stop();
  endtask
  initial begin
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    chk("rel", 8'h01, {7'h0, oe_n});
    repeat (8) @(negedge clk_i);
    s_page();
    rd2(8'h7f, 8'hfe, 8'ha1, 8'hb2);
    rd2(8'h7f, 8'hc0, 8'hc3, 8'hd4);
    s_protect();
    s_select();
    conclude();
  end
endmodule // tb_serial_eeprom_select_and_protect
`default_nettype wire
